// ---- cgs_pkg.sv ----
// Constants and types for the clock generator squelch/margin/detect register slice.
// Assumes a 32-bit Avalon-MM slave with byte addresses equal to four times the register index.
package cgs_pkg;

  // Register indices; the byte address is the index times four
  localparam logic [7:0] IDX_CH_SQUELCH     = 8'h16;
  localparam logic [7:0] IDX_STATUS_SQUELCH = 8'h17;
  localparam logic [7:0] IDX_MARGIN_EN      = 8'h18;
  localparam logic [7:0] IDX_REF_DETECT     = 8'h19;
  localparam logic [7:0] IDX_SQUELCH_STATE  = 8'h1a;
  localparam logic [7:0] IDX_LIVE_STATE     = 8'h1b;

  // Bus geometry
  localparam int AV_ADDR_W = 8;
  localparam int AV_DATA_W = 32;
  localparam int REG_W     = 8;

  // Field positions
  localparam int PIN_ONE_SQ_BIT  = 1;
  localparam int PIN_ZERO_SQ_BIT = 0;
  localparam int SEC_METHOD_LSB  = 6;
  localparam int SEC_METHOD_W    = 2;
  localparam int LIVE_VALID_BIT  = 2;
  localparam int LIVE_MARGIN_LSB = 2;

  // Counts
  localparam int NUM_STATUS_PINS = 2;
  localparam int NUM_CHANNELS    = 8;
  localparam int NUM_DIVIDERS    = 6;
  localparam int DIV_VALUE_W     = 8;
  localparam int MARGIN_MIN_DIV  = 8;

  // Reset values
  localparam logic [7:0] RST_CH_SQUELCH     = 8'hff;
  localparam logic [7:0] RST_STATUS_SQUELCH = 8'h02;
  localparam logic [7:0] RST_MARGIN_EN      = 8'h00;
  localparam logic [7:0] RST_REF_DETECT     = 8'h55;

  // Writable bit masks; reserved bits hold zero
  localparam logic [7:0] MASK_STATUS_SQUELCH = 8'h03;
  localparam logic [7:0] MASK_MARGIN_EN      = 8'h3f;

  // Secondary reference detection method encoding
  typedef enum logic [1:0] {
    SEC_RISE_SLEW  = 2'h0,
    SEC_BOTH_SLEW  = 2'h1,
    SEC_FALL_SLEW  = 2'h2,
    SEC_LEVEL_DET  = 2'h3
  } cgs_sec_method_t;

  // Detector enables handed to the secondary energy detector
  typedef struct packed {
    logic rise_slew_en;
    logic fall_slew_en;
    logic level_det_en;
  } cgs_detect_sel_t;

  // Squelch results for the pins and channels
  typedef struct packed {
    logic [NUM_CHANNELS-1:0]    ch_run;
    logic [NUM_STATUS_PINS-1:0] status_run;
  } cgs_run_state_t;

endpackage

// ---- cgs_regs.sv ----
// Squelch, divider margining and secondary reference detect register slice.
// Assumes one clock, an Avalon-MM master, and validity/divider inputs from same-clock logic.
//
// Overview of operation
// - Pin one as clock with squelch set is disabled while source invalid.
// - Pin one squelch clear keeps the pin running whatever the source.
// - Pin one not carrying a clock runs normally, squelch ignored.
// - Pin zero as clock with squelch set is disabled while source invalid.
// - Pin zero squelch clear keeps the pin running whatever the source.
// - Pin zero not carrying a clock runs normally, squelch ignored.
// - Pin one squelch is bit 1 of status squelch register, RW, reset 1.
// - Pin zero squelch is bit 0 of status squelch register, RW, reset 0.
// - Margin enable acts on its divider only when divide value exceeds 8.
// - Margin bits 5..2 map to channel dividers 7..4.
// - Margin bit 1 controls the shared divider of channels 2 and 3.
// - Margin bit 0 controls the shared divider of channels 0 and 1.
// - All six margin enables are RW and reset to 0.
// - Secondary detect method is bits 7:6 of reference detect, RW, reset 1.
// - Method 0 rising, 1 both edges, 2 falling, 3 level detector.
// - Each of eight channels has squelch, reset 1, muting while source invalid.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cgs_regs #(
  parameter int DIV_W = cgs_pkg::DIV_VALUE_W
) (
  // Clock and reset
  input  wire logic                                      i_clk,
  input  wire logic                                      i_rst_b,
  // Avalon-MM slave
  input  wire logic [cgs_pkg::AV_ADDR_W-1:0]             i_avs_address,
  input  wire logic                                      i_avs_read,
  input  wire logic                                      i_avs_write,
  input  wire logic [cgs_pkg::AV_DATA_W-1:0]             i_avs_writedata,
  input  wire logic [3:0]                                i_avs_byteenable,
  output logic      [cgs_pkg::AV_DATA_W-1:0]             o_avs_readdata,
  output logic                                           o_avs_waitrequest,
  // Clock source health and output configuration
  input  wire logic                                      i_src_valid,
  input  wire logic [cgs_pkg::NUM_STATUS_PINS-1:0]       i_status_is_clock,
  // Divider values, divider d in bits [d*DIV_W +: DIV_W]
  input  wire logic [cgs_pkg::NUM_DIVIDERS*DIV_W-1:0]    i_div_value,
  // Squelch results
  output cgs_pkg::cgs_run_state_t                        o_run_state,
  // Margining to the dividers
  output logic      [cgs_pkg::NUM_DIVIDERS-1:0]          o_margin_en,
  output logic      [cgs_pkg::NUM_DIVIDERS-1:0]          o_margin_active,
  // Secondary reference detector
  output cgs_pkg::cgs_sec_method_t                       o_sec_method,
  output cgs_pkg::cgs_detect_sel_t                       o_sec_detect,
  output logic      [cgs_pkg::SEC_METHOD_LSB-1:0]        o_refdet_other
);

  // Byte address of a register index
  function automatic logic hit(input logic [cgs_pkg::AV_ADDR_W-1:0] addr,
                               input logic [7:0]                    idx);
    hit = (addr == {idx[cgs_pkg::AV_ADDR_W-3:0], 2'b00});
  endfunction

  // Detector enables from the method code
  function automatic cgs_pkg::cgs_detect_sel_t decode_method(input cgs_pkg::cgs_sec_method_t m);
    cgs_pkg::cgs_detect_sel_t d;
    d = '0;
    case (m)
      cgs_pkg::SEC_RISE_SLEW: d.rise_slew_en = 1'b1;
      cgs_pkg::SEC_BOTH_SLEW: begin
        d.rise_slew_en = 1'b1;
        d.fall_slew_en = 1'b1;
      end
      cgs_pkg::SEC_FALL_SLEW: d.fall_slew_en = 1'b1;
      cgs_pkg::SEC_LEVEL_DET: d.level_det_en = 1'b1;
      default:                d = '0;
    endcase
    decode_method = d;
  endfunction

  // Register storage
  logic [cgs_pkg::REG_W-1:0]     ch_squelch_reg;
  logic [cgs_pkg::REG_W-1:0]     status_squelch_reg;
  logic [cgs_pkg::REG_W-1:0]     margin_en_reg;
  logic [cgs_pkg::REG_W-1:0]     ref_detect_reg;
  logic                          ack_reg;
  logic [cgs_pkg::AV_DATA_W-1:0] rdata_reg;
  logic [cgs_pkg::AV_DATA_W-1:0] rdata_next;

  // Bus handshake: one wait state, then the transfer completes
  wire req       = i_avs_read | i_avs_write;
  wire wr_fire   = i_avs_write & ack_reg & i_avs_byteenable[0];
  wire wr_data_7 = 1'b0;
  wire [7:0] wdat = i_avs_writedata[7:0];

  // Address decode
  wire hit_ch     = hit(i_avs_address, cgs_pkg::IDX_CH_SQUELCH);
  wire hit_status = hit(i_avs_address, cgs_pkg::IDX_STATUS_SQUELCH);
  wire hit_margin = hit(i_avs_address, cgs_pkg::IDX_MARGIN_EN);
  wire hit_refdet = hit(i_avs_address, cgs_pkg::IDX_REF_DETECT);
  wire hit_sqst   = hit(i_avs_address, cgs_pkg::IDX_SQUELCH_STATE);
  wire hit_live   = hit(i_avs_address, cgs_pkg::IDX_LIVE_STATE);

  assign o_avs_waitrequest = req & ~ack_reg;

  // Handshake state; cleared after each beat so back-to-back requests each wait once
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Writable registers, reserved bits masked off on the way in
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ch_squelch_reg     <= cgs_pkg::RST_CH_SQUELCH;
      status_squelch_reg <= cgs_pkg::RST_STATUS_SQUELCH;
      margin_en_reg      <= cgs_pkg::RST_MARGIN_EN;
      ref_detect_reg     <= cgs_pkg::RST_REF_DETECT;
    end else if (wr_fire) begin
      if (hit_ch) begin
        ch_squelch_reg <= wdat;
      end
      if (hit_status) begin
        status_squelch_reg <= wdat & cgs_pkg::MASK_STATUS_SQUELCH;
      end
      if (hit_margin) begin
        margin_en_reg <= wdat & cgs_pkg::MASK_MARGIN_EN;
      end
      if (hit_refdet) begin
        ref_detect_reg <= wdat;
      end
    end
  end

  // Squelch gates for status pins and output channels
  cgs_pkg::cgs_run_state_t run_state;

  cgs_squelch #(
    .N (cgs_pkg::NUM_STATUS_PINS)
  ) u_status_gate (
    .i_clk        (i_clk),
    .i_rst_b      (i_rst_b),
    .i_squelch_en ({status_squelch_reg[cgs_pkg::PIN_ONE_SQ_BIT],
                    status_squelch_reg[cgs_pkg::PIN_ZERO_SQ_BIT]}),
    .i_is_clock   (i_status_is_clock),
    .i_src_valid  (i_src_valid),
    .o_run        (run_state.status_run)
  );

  // Channels always carry a clock, so only squelch and validity decide
  cgs_squelch #(
    .N (cgs_pkg::NUM_CHANNELS)
  ) u_channel_gate (
    .i_clk        (i_clk),
    .i_rst_b      (i_rst_b),
    .i_squelch_en (ch_squelch_reg),
    .i_is_clock   ({cgs_pkg::NUM_CHANNELS{1'b1}}),
    .i_src_valid  (i_src_valid),
    .o_run        (run_state.ch_run)
  );

  assign o_run_state = run_state;

  // Margin enables per divider: bit 0 ch0/1, bit 1 ch2/3, bits 2..5 ch4..7
  logic [cgs_pkg::NUM_DIVIDERS-1:0] margin_active_reg;
  logic [cgs_pkg::NUM_DIVIDERS-1:0] margin_active_next;
  localparam logic [DIV_W-1:0] MIN_DIV = DIV_W'(cgs_pkg::MARGIN_MIN_DIV);

  genvar d;
  generate
    for (d = 0; d < cgs_pkg::NUM_DIVIDERS; d++) begin : g_margin
      // At or below the limit the divider cannot margin; the enable is held off
      assign margin_active_next[d] = margin_en_reg[d] & (i_div_value[d*DIV_W +: DIV_W] > MIN_DIV);
    end
  endgenerate

  // Margin outputs registered so the dividers see clean levels
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      margin_active_reg <= '0;
    end else begin
      margin_active_reg <= margin_active_next;
    end
  end

  assign o_margin_en     = margin_en_reg[cgs_pkg::NUM_DIVIDERS-1:0];
  assign o_margin_active = margin_active_reg;

  // Secondary reference detection method
  wire [cgs_pkg::SEC_METHOD_W-1:0] sec_bits = ref_detect_reg[cgs_pkg::SEC_METHOD_LSB +: cgs_pkg::SEC_METHOD_W];
  assign o_sec_method   = cgs_pkg::cgs_sec_method_t'(sec_bits);
  assign o_sec_detect   = decode_method(cgs_pkg::cgs_sec_method_t'(sec_bits));
  assign o_refdet_other = ref_detect_reg[cgs_pkg::SEC_METHOD_LSB-1:0];

  // Live state word: valid flag above the two status pin gates
  wire [7:0] live_word = {5'h00, i_src_valid, run_state.status_run};

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = '0;
    if (hit_ch) begin
      rdata_next[7:0] = ch_squelch_reg;
    end else if (hit_status) begin
      rdata_next[7:0] = status_squelch_reg & cgs_pkg::MASK_STATUS_SQUELCH;
    end else if (hit_margin) begin
      rdata_next[7:0] = margin_en_reg & cgs_pkg::MASK_MARGIN_EN;
    end else if (hit_refdet) begin
      rdata_next[7:0] = ref_detect_reg;
    end else if (hit_sqst) begin
      rdata_next[7:0] = run_state.ch_run;
    end else if (hit_live) begin
      rdata_next[7:0] = {margin_active_reg, live_word[1:0]} | {5'h00, live_word[2], 2'b00};
    end
  end

  // Read data captured during the wait state and held through completion
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= '0;
    end else if (i_avs_read & ~ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_avs_readdata = rdata_reg;

  // Unused: kept so the byte-wide write path stays explicit
  wire unused_ok = wr_data_7 & (|i_avs_writedata[31:8]) & (|i_avs_byteenable[3:1]);

endmodule

`default_nettype wire

// ---- cgs_regs_checker.sv ----
// Assertions on the squelch, margin and detect register slice.
// Assumes binding to cgs_regs; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cgs_regs_checker #(
  parameter int DIV_W = 8
) (
  // Clock, reset and bus
  input wire logic                        i_clk,
  input wire logic                        i_rst_b,
  input wire logic [7:0]                  i_avs_address,
  input wire logic                        i_avs_read,
  input wire logic                        i_avs_write,
  input wire logic [31:0]                 i_avs_writedata,
  input wire logic [3:0]                  i_avs_byteenable,
  input wire logic [31:0]                 o_avs_readdata,
  input wire logic                        o_avs_waitrequest,
  // Health, configuration and results
  input wire logic                        i_src_valid,
  input wire logic [1:0]                  i_status_is_clock,
  input wire logic [6*DIV_W-1:0]          i_div_value,
  input wire cgs_pkg::cgs_run_state_t     o_run_state,
  input wire logic [5:0]                  o_margin_en,
  input wire logic [5:0]                  o_margin_active,
  input wire cgs_pkg::cgs_sec_method_t    o_sec_method,
  input wire cgs_pkg::cgs_detect_sel_t    o_sec_detect
);
  logic [5:0] div_gt;
  wire logic  wr_done;

  // Strict compare: a divide of exactly 8 must stay unmargined
  always_comb for (int d = 0; d < 6; d++) div_gt[d] = i_div_value[d*DIV_W +: DIV_W] > 8;
  assign wr_done = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  ch_run_a:
    assert property ($past(i_src_valid) |-> &o_run_state.ch_run) else $error("channel squelched, source valid");
  pin_one_run_a:
    assert property (!$past(i_status_is_clock[1] & ~i_src_valid) |-> o_run_state.status_run[1])
      else $error("pin one stopped without cause");
  pin_zero_run_a:
    assert property (!$past(i_status_is_clock[0] & ~i_src_valid) |-> o_run_state.status_run[0])
      else $error("pin zero stopped without cause");
  margin_act_a:
    assert property (o_margin_active == $past(o_margin_en & div_gt)) else $error("margin active wrong");
  sec_decode_a:
    assert property (o_sec_detect == {o_sec_method < 2'h2, o_sec_method inside {2'h1, 2'h2}, o_sec_method == 2'h3})
      else $error("detector decode wrong");
  sec_write_a:
    assert property (wr_done && i_avs_address == 8'h64 |=> o_sec_method == $past(i_avs_writedata[7:6]))
      else $error("method not stored");
  margin_write_a:
    assert property (wr_done && i_avs_address == 8'h60 |=> o_margin_en == $past(i_avs_writedata[5:0]))
      else $error("margin enables not stored");
  sq_reserved_a:
    assert property (i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h5c |-> o_avs_readdata[7:2] == 6'h00)
      else $error("reserved squelch bits nonzero");
  wait_state_a:
    assert property ($rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("wait state count wrong");
endmodule
bind cgs_regs cgs_regs_checker #(.DIV_W(DIV_W)) i_cgs_regs_checker (.i_clk, .i_rst_b, .i_avs_address,
  .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
  .i_src_valid, .i_status_is_clock, .i_div_value, .o_run_state, .o_margin_en, .o_margin_active,
  .o_sec_method, .o_sec_detect);
`default_nettype wire

// ---- cgs_regs_test.sv ----
// Self-checking bench for the squelch, margin and detect register slice.
// Assumes the bench is the only bus master and drives every input itself.
`timescale 1ns/1ps
`default_nettype none
module cgs_regs_test;
  // Stimulus
  logic        i_clk = 1'b0, i_rst_b = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0, i_src_valid = 1'b1;
  logic [7:0]  i_avs_address = 8'h00;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0]  i_avs_byteenable = 4'h1;
  logic [1:0]  i_status_is_clock = 2'h0;
  logic [47:0] i_div_value = 48'h08_09_08_09_08_09; // Even dividers 9, odd ones exactly 8
  // Observed
  logic [31:0]                 o_avs_readdata, rd_val;
  logic                        o_avs_waitrequest;
  cgs_pkg::cgs_run_state_t     o_run_state;
  logic [5:0]                  o_margin_en, o_margin_active, o_refdet_other;
  cgs_pkg::cgs_sec_method_t    o_sec_method;
  cgs_pkg::cgs_detect_sel_t    o_sec_detect;
  logic [2:0]                  det [4] = '{3'h4, 3'h6, 3'h2, 3'h1};
  int                          err_count = 0, cmp_count = 0;

  cgs_regs #(.DIV_W(8)) i_cgs_regs (.i_clk, .i_rst_b, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_src_valid,
    .i_status_is_clock, .i_div_value, .o_run_state, .o_margin_en, .o_margin_active, .o_sec_method,
    .o_sec_detect, .o_refdet_other);

  // Verdict and counts
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Compare, case equality so unknowns fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_read <= !wr;
    i_avs_write <= wr;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do begin
      @(posedge i_clk);
      n++;
      if (n > 20) begin
        err_count++;
        $display("BAD %0t bus timeout", $time);
        end_of_test();
      end
    end while (o_avs_waitrequest);
    rd_val = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd_val, exp);
  endtask

  // Registered outputs settle within two edges of a write or input change
  task automatic pause();
    repeat (2) @(posedge i_clk);
  endtask

  initial forever #12.5 i_clk = ~i_clk;

  // Main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(8'h58, 32'hff);
    rd(8'h5c, 32'h02);
    rd(8'h60, 32'h00);
    rd(8'h64, 32'h55);
    i_status_is_clock <= 2'h3;
    i_src_valid <= 1'b0;
    pause();
    chk(o_run_state, 32'h001);
    $display("test reset done");
    // Squelch on and off, then pins not carrying a clock
    bus(1'b1, 8'h5c, 32'h03);
    pause();
    chk(o_run_state, 32'h000);
    i_src_valid <= 1'b1;
    pause();
    chk(o_run_state, 32'h3ff);
    i_src_valid <= 1'b0;
    bus(1'b1, 8'h5c, 32'h00);
    pause();
    chk(o_run_state, 32'h003);
    bus(1'b1, 8'h5c, 32'h03);
    bus(1'b1, 8'h58, 32'h0f);
    i_status_is_clock <= 2'h0;
    pause();
    chk(o_run_state, 32'h3c3);
    rd(8'h68, 32'hf0);
    $display("test squelch done");
    // Reserved bits, unmapped place, disabled byte lane
    bus(1'b1, 8'h5c, 32'hff);
    rd(8'h5c, 32'h03);
    bus(1'b1, 8'h60, 32'hff);
    rd(8'h60, 32'h3f);
    bus(1'b1, 8'h70, 32'h5a);
    rd(8'h70, 32'h00);
    i_avs_byteenable <= 4'he;
    bus(1'b1, 8'h60, 32'h00);
    i_avs_byteenable <= 4'h1;
    rd(8'h60, 32'h3f);
    chk(o_margin_active, 32'h15);
    rd(8'h6c, 32'h57);
    $display("test reserved done");
    // Each margin bit alone, boundary divide of 8 against 9
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, 8'h60, 32'h1 << k);
      pause();
      chk({o_margin_active, o_margin_en}, {6'h15 & (6'h1 << k), 6'h1 << k});
    end
    $display("test margin done");
    // Every detection method
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h64, {24'h0, 2'(m), 6'h15});
      pause();
      chk({o_sec_method, o_sec_detect, o_refdet_other}, {2'(m), det[m], 6'h15});
    end
    $display("test method done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- cgs_squelch.sv ----
// Per-output automatic squelch gate, one bit per output.
// Assumes the source-valid flag and configuration come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module cgs_squelch #(
  parameter int N = 2
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // Configuration
  input  wire logic [N-1:0] i_squelch_en,
  input  wire logic [N-1:0] i_is_clock,
  // Selected source health
  input  wire logic         i_src_valid,
  // Gate result, 1 means the output runs
  output logic      [N-1:0] o_run
);

  logic [N-1:0] run_reg;
  logic [N-1:0] run_next;

  // Mute only a clock-carrying output whose squelch is on while the source is bad
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_gate
      assign run_next[g] = ~(i_is_clock[g] & i_squelch_en[g] & ~i_src_valid);
    end
  endgenerate

  // Outputs run until told otherwise; a glitch-free registered gate
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_reg <= {N{1'b1}};
    end else begin
      run_reg <= run_next;
    end
  end

  assign o_run = run_reg;

endmodule

`default_nettype wire
